// [ration_defines.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the ration bank
// Assumes: 8-bit register port, byte addresses as used by the serial host
// Notes:   Definitions only
`ifndef RATION_DEFINES_SVH
`define RATION_DEFINES_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_P2_LIMIT_HI      8'h1e
`define ADDR_P2_LIMIT_LO      8'h1f
`define ADDR_P1_LIMIT_HI      8'h20
`define ADDR_P1_LIMIT_LO      8'h21
`define ADDR_RATION_CONFIG    8'h22
`define ADDR_P2_LIMIT_BEH     8'h23
`define ADDR_P1_LIMIT_BEH     8'h24
`define ADDR_P2_TOTAL_B3      8'h16
`define ADDR_P1_TOTAL_B3      8'h1a

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CHARGE_LIMIT      16'hffff
`define RST_RATION_CONFIG     8'h11
`define RST_LIMIT_BEH         8'h96

// ----------------------------------------
// Ration configuration fields (port 1 high nibble, port 2 low nibble)
// ----------------------------------------
`define RC_P1_ON              7
`define RC_P1_CLEAR           6
`define RC_P1_RESP_HI         5
`define RC_P2_ON              3
`define RC_P2_CLEAR           2
`define RC_P2_RESP_HI         1

// ----------------------------------------
// Limit behaviour fields
// ----------------------------------------
`define LB_VOLT_HI            7
`define LB_DRAIN              5
`define LB_CUR_HI             4

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ                25000000
`define UPDATE_PERIOD_S       1
`define UPDATE_CYCLES         (`CLK_HZ * `UPDATE_PERIOD_S)
`define TOTAL_WIDTH           26
`define LIMIT_WIDTH           16

`endif

// [ration_pkg.sv]
// Purpose: Types shared by the ration bank
// Assumes: Nothing beyond SystemVerilog
// Notes:   Response codes of the two-bit ration behaviour field
package ration_pkg;
   typedef enum logic [1:0] {
      RESP_NONE       = 2'b00,
      RESP_REPORT     = 2'b01,
      RESP_DISCONNECT = 2'b10,
      RESP_IGNORE     = 2'b11
   } resp_e;
endpackage

// [port_ration_ctr.sv]
// Purpose: Per-port charge accumulator with threshold compare
// Assumes: Charge increments arrive already scaled to accumulator counts
// Notes:   Accumulates only on the one-second tick while active
`include "ration_defines.svh"
module port_ration_ctr #(
   parameter int TOTAL_W = `TOTAL_WIDTH,
   parameter int LIMIT_W = `LIMIT_WIDTH
) (
   input  wire logic                 sys_clk,
   input  wire logic                 reset_n,
   input  wire logic                 tick,
   input  wire logic                 active,
   input  wire logic                 ration_on,
   input  wire logic                 ration_clear,
   input  wire logic [15:0]          charge_step,
   input  wire logic [LIMIT_W-1:0]   charge_limit,
   output logic      [TOTAL_W-1:0]   charge_total,
   output logic                      quota_hit
);
   initial begin
      if (TOTAL_W < LIMIT_W + 10 || LIMIT_W < 1)
         $error("port_ration_ctr: unsupported widths");
   end

   typedef struct packed {
      logic [TOTAL_W-1:0] total;
      logic               hit;
   } st_s;

   st_s st_r;
   st_s st_nxt;

   // Threshold counts ~1024 accumulator counts (3.76 / 0.00367)
   logic [TOTAL_W:0] limit_scaled;
   logic [TOTAL_W:0] next_sum;
   assign limit_scaled = {1'b0, charge_limit, 10'h000};
   assign next_sum = {1'b0, st_r.total} + {{(TOTAL_W-15){1'b0}}, charge_step};

   always_comb begin
      st_nxt = st_r;
      if (!ration_on || ration_clear) begin
         st_nxt.total = '0;                                      // R2 R4
         st_nxt.hit   = 1'b0;                                    // R3 R4
      end else if (tick && active) begin                        // R15
         // Saturate at all ones instead of wrapping past the accumulator maximum
         st_nxt.total = next_sum[TOTAL_W] ? '1 : next_sum[TOTAL_W-1:0];
         if (next_sum >= limit_scaled)                           // R14
            st_nxt.hit = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign charge_total = st_r.total;                             // R16
   assign quota_hit    = st_r.hit;
endmodule

// [port_charge_ration_regs.sv]
// Overview of operation
// (R1) Each port has a 16-bit writable threshold, 3.76 mAh per count, reset all ones.
// (R2) Ration enable low forces accumulated charge to zero and stops accumulation.
// (R3) Disabling rationing removes applied response and clears the port's ration flag.
// (R4) Ration clear zeroes charge, clears flag, releases alert if nothing else holds it.
// (R5) Host must return ration clear to zero before rationing works again.
// (R6) Two-bit minimum bus voltage select: 1.50, 1.75, 2.0, 2.25 V; reset 10.
// (R7) Drain bit connects internal 100 ohm load; host sets it when auto drain off.
// (R8) Manual drain has no timer; host times it and clears the bit.
// (R9) Drain bit ignored while auto drain enable is one; timed drain used instead.
// (R10) Switch stays on with drain set; internal load parallels the external load.
// (R11) Three-bit R2 minimum current select: 100 to 2130 mA over codes 000..101.
// (R12) Host keeps the two low reserved behaviour bits at their reset pattern 1,0.
// (R13) Behaviour registers lose contents in sleep and return to reset values.
// (R14) On each charge update compare with threshold; at or above, flag and respond.
// (R15) Accumulated charge updates once per second while in the active state.
// (R16) Accumulated charge is 26 bits, 0.00367 mAh per count.
// (R17) Two-bit response field, reset 01: off, report, disconnect-and-sleep, ignore.
//
// Purpose: Ration and current-limit behaviour register bank for a two-port switch
// Assumes: Byte-wide register port from the serial front end, one-cycle strobes
// Notes:   Response code 00 treated as no action
`include "ration_defines.svh"
module port_charge_ration_regs #(
   parameter int UPDATE_CYCLES = `UPDATE_CYCLES
) (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic        active,
   input  wire logic        sleep,
   input  wire logic        auto_drain_enable,
   input  wire logic        p1_switch_on,
   input  wire logic        p2_switch_on,
   input  wire logic        p1_other_alert,
   input  wire logic        p2_other_alert,
   input  wire logic [15:0] p1_charge_step,
   input  wire logic [15:0] p2_charge_step,
   output logic      [7:0]  reg_rdata,
   output logic             p1_drain_load,
   output logic             p2_drain_load,
   output logic             p1_switch_gate,
   output logic             p2_switch_gate,
   output logic             p1_alert_n,
   output logic             p2_alert_n,
   output logic             sleep_req,
   output logic             p1_quota_hit_flag,
   output logic             p2_quota_hit_flag,
   output logic      [1:0]  p1_min_bus_volt_sel,
   output logic      [1:0]  p2_min_bus_volt_sel,
   output logic      [2:0]  p1_r2_min_current_sel,
   output logic      [2:0]  p2_r2_min_current_sel
);
   initial begin
      if (UPDATE_CYCLES < 2)
         $error("port_charge_ration_regs: UPDATE_CYCLES too small");
   end

   localparam int TW = `TOTAL_WIDTH;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [15:0] p1_charge_limit;
      logic [15:0] p2_charge_limit;
      logic [7:0]  ration_config;
      logic [7:0]  p1_limit_beh;
      logic [7:0]  p2_limit_beh;
      logic [31:0] tick_cnt;
      logic        tick;
      logic [7:0]  rdata;
      logic [1:0]  drain;
      logic [1:0]  gate;
      logic [1:0]  alert_n;
      logic        sleep_req;
   } st_s;

   st_s st_r;
   st_s st_nxt;

   logic [TW-1:0] p1_charge_total;
   logic [TW-1:0] p2_charge_total;
   logic          p1_hit;
   logic          p2_hit;

   // Response in force only while the flag is set
   function automatic logic resp_is(input logic [1:0] code, input ration_pkg::resp_e r);
      resp_is = (code == r);
   endfunction

   function automatic logic [7:0] total_byte(input logic [TW-1:0] t, input logic [1:0] idx);
      logic [31:0] w;
      w = {t, 6'h00};
      case (idx)
         2'd0:    total_byte = w[31:24];
         2'd1:    total_byte = w[23:16];
         2'd2:    total_byte = w[15:8];
         default: total_byte = w[7:0];
      endcase
   endfunction

   // ----------------------------------------
   // Per-port accumulators
   // ----------------------------------------
   port_ration_ctr #(.TOTAL_W(TW), .LIMIT_W(`LIMIT_WIDTH)) u_p1 (
      .sys_clk      (sys_clk),
      .reset_n      (reset_n),
      .tick         (st_r.tick),
      .active       (active),
      .ration_on    (st_r.ration_config[`RC_P1_ON]),                 // R2
      .ration_clear (st_r.ration_config[`RC_P1_CLEAR]),              // R4 R5
      .charge_step  (p1_charge_step),
      .charge_limit (st_r.p1_charge_limit),
      .charge_total (p1_charge_total),
      .quota_hit    (p1_hit)
   );

   port_ration_ctr #(.TOTAL_W(TW), .LIMIT_W(`LIMIT_WIDTH)) u_p2 (
      .sys_clk      (sys_clk),
      .reset_n      (reset_n),
      .tick         (st_r.tick),
      .active       (active),
      .ration_on    (st_r.ration_config[`RC_P2_ON]),                 // R2
      .ration_clear (st_r.ration_config[`RC_P2_CLEAR]),              // R4 R5
      .charge_step  (p2_charge_step),
      .charge_limit (st_r.p2_charge_limit),
      .charge_total (p2_charge_total),
      .quota_hit    (p2_hit)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   logic [1:0] resp1;
   logic [1:0] resp2;
   assign resp1 = st_r.ration_config[`RC_P1_RESP_HI -: 2];
   assign resp2 = st_r.ration_config[`RC_P2_RESP_HI -: 2];

   always_comb begin
      st_nxt = st_r;

      // One-second update tick
      if (st_r.tick_cnt >= 32'(UPDATE_CYCLES - 1)) begin            // R15
         st_nxt.tick_cnt = '0;
         st_nxt.tick     = 1'b1;
      end else begin
         st_nxt.tick_cnt = st_r.tick_cnt + 32'h0000_0001;
         st_nxt.tick     = 1'b0;
      end

      if (reg_wr) begin
         case (reg_addr)
            `ADDR_P1_LIMIT_HI:   st_nxt.p1_charge_limit[15:8] = reg_wdata;   // R1
            `ADDR_P1_LIMIT_LO:   st_nxt.p1_charge_limit[7:0]  = reg_wdata;   // R1
            `ADDR_P2_LIMIT_HI:   st_nxt.p2_charge_limit[15:8] = reg_wdata;   // R1
            `ADDR_P2_LIMIT_LO:   st_nxt.p2_charge_limit[7:0]  = reg_wdata;   // R1
            `ADDR_RATION_CONFIG: st_nxt.ration_config         = reg_wdata;   // R17
            `ADDR_P2_LIMIT_BEH:  st_nxt.p2_limit_beh          = reg_wdata;   // R6 R11
            `ADDR_P1_LIMIT_BEH:  st_nxt.p1_limit_beh          = reg_wdata;   // R6 R11
            default: ;
         endcase
      end

      // Behaviour registers are volatile across sleep
      if (sleep) begin
         st_nxt.p1_limit_beh = `RST_LIMIT_BEH;                      // R13
         st_nxt.p2_limit_beh = `RST_LIMIT_BEH;                      // R13
      end

      st_nxt.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            `ADDR_P1_LIMIT_HI:   st_nxt.rdata = st_r.p1_charge_limit[15:8];
            `ADDR_P1_LIMIT_LO:   st_nxt.rdata = st_r.p1_charge_limit[7:0];
            `ADDR_P2_LIMIT_HI:   st_nxt.rdata = st_r.p2_charge_limit[15:8];
            `ADDR_P2_LIMIT_LO:   st_nxt.rdata = st_r.p2_charge_limit[7:0];
            `ADDR_RATION_CONFIG: st_nxt.rdata = st_r.ration_config;
            `ADDR_P2_LIMIT_BEH:  st_nxt.rdata = st_r.p2_limit_beh;
            `ADDR_P1_LIMIT_BEH:  st_nxt.rdata = st_r.p1_limit_beh;
            8'h16, 8'h17, 8'h18, 8'h19:
               st_nxt.rdata = total_byte(p2_charge_total, 2'(reg_addr - `ADDR_P2_TOTAL_B3));
            8'h1a, 8'h1b, 8'h1c, 8'h1d:
               st_nxt.rdata = total_byte(p1_charge_total, 2'(reg_addr - `ADDR_P1_TOTAL_B3));
            default: st_nxt.rdata = 8'h00;
         endcase
      end

      // Manual drain only counts while automatic drain is off
      st_nxt.drain[0] = st_r.p1_limit_beh[`LB_DRAIN] && !auto_drain_enable;  // R7 R9
      st_nxt.drain[1] = st_r.p2_limit_beh[`LB_DRAIN] && !auto_drain_enable;  // R7 R9

      // Switch follows enable regardless of drain; disconnect only on a hit
      st_nxt.gate[0] = p1_switch_on &&                                     // R10
                       !(p1_hit && resp_is(resp1, ration_pkg::RESP_DISCONNECT)); // R14
      st_nxt.gate[1] = p2_switch_on &&                                     // R10
                       !(p2_hit && resp_is(resp2, ration_pkg::RESP_DISCONNECT)); // R14

      // Flag clears drop the alert unless another source still holds it
      st_nxt.alert_n[0] = !(p1_other_alert ||                              // R4
                            (p1_hit && !resp_is(resp1, ration_pkg::RESP_IGNORE) &&
                             !resp_is(resp1, ration_pkg::RESP_NONE)));     // R17
      st_nxt.alert_n[1] = !(p2_other_alert ||                              // R4
                            (p2_hit && !resp_is(resp2, ration_pkg::RESP_IGNORE) &&
                             !resp_is(resp2, ration_pkg::RESP_NONE)));     // R17
      st_nxt.sleep_req = (p1_hit && resp_is(resp1, ration_pkg::RESP_DISCONNECT)) ||
                         (p2_hit && resp_is(resp2, ration_pkg::RESP_DISCONNECT)); // R3
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         st_r                 <= '0;
         st_r.p1_charge_limit <= `RST_CHARGE_LIMIT;                 // R1
         st_r.p2_charge_limit <= `RST_CHARGE_LIMIT;                 // R1
         st_r.ration_config   <= `RST_RATION_CONFIG;                // R17
         st_r.p1_limit_beh    <= `RST_LIMIT_BEH;                    // R6
         st_r.p2_limit_beh    <= `RST_LIMIT_BEH;                    // R6
         st_r.alert_n         <= 2'b11;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign reg_rdata             = st_r.rdata;
   assign p1_drain_load         = st_r.drain[0];
   assign p2_drain_load         = st_r.drain[1];
   assign p1_switch_gate        = st_r.gate[0];
   assign p2_switch_gate        = st_r.gate[1];
   assign p1_alert_n            = st_r.alert_n[0];
   assign p2_alert_n            = st_r.alert_n[1];
   assign sleep_req             = st_r.sleep_req;
   assign p1_quota_hit_flag     = p1_hit;
   assign p2_quota_hit_flag     = p2_hit;
   assign p1_min_bus_volt_sel   = st_r.p1_limit_beh[`LB_VOLT_HI -: 2];     // R6
   assign p2_min_bus_volt_sel   = st_r.p2_limit_beh[`LB_VOLT_HI -: 2];     // R6
   assign p1_r2_min_current_sel = st_r.p1_limit_beh[`LB_CUR_HI -: 3];      // R11
   assign p2_r2_min_current_sel = st_r.p2_limit_beh[`LB_CUR_HI -: 3];      // R11
endmodule

// [host_model.sv]
// Purpose: Serial host model driving the byte register port
// Assumes: One-cycle strobes, read data one cycle after the strobe
// Notes:   Released address and data lines show inverted values
module host_model (
   input  wire logic       sys_clk,
   input  wire logic [7:0] reg_rdata,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      #1 d = reg_rdata;
   endtask
   // Reserved low pair always rewritten as 1,0
   task automatic beh(input logic [7:0] a, input logic [1:0] v, input logic dr,
                      input logic [2:0] c);
      wr(a, {v, dr, c, 2'b10});
   endtask
endmodule

// [ration_monitor.sv]
// Purpose: Pin-level checks of the ration bank
// Assumes: Sees top-level pins only
// Notes:   Response-specific outputs are judged by the bench
module ration_monitor (
   input wire logic       sys_clk,
   input wire logic       reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       sleep,
   input wire logic       auto_drain_enable,
   input wire logic       p1_switch_on,
   input wire logic       p1_other_alert,
   input wire logic       p1_drain_load,
   input wire logic       p1_switch_gate,
   input wire logic       p1_alert_n,
   input wire logic       p1_quota_hit_flag,
   input wire logic       p2_quota_hit_flag,
   input wire logic [1:0] p1_min_bus_volt_sel,
   input wire logic [2:0] p1_r2_min_current_sel
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
   property p_unmapped; reg_rd && (reg_addr < 8'h16 || reg_addr > 8'h24) |=> reg_rdata == 8'h00;
   endproperty
   property p_auto_drain; auto_drain_enable ##1 auto_drain_enable |=> !p1_drain_load; endproperty
   property p_gate; p1_switch_on && !p1_quota_hit_flag |=> p1_switch_gate; endproperty
   property p_other; p1_other_alert |=> !p1_alert_n; endproperty
   property p_release; !p1_other_alert && !p1_quota_hit_flag |=> p1_alert_n; endproperty
   property p_disable; reg_wr && reg_addr == 8'h22 && !reg_wdata[3] |-> ##[1:3] !p2_quota_hit_flag;
   endproperty
   property p_clear; reg_wr && reg_addr == 8'h22 && reg_wdata[6] |-> ##[1:3] !p1_quota_hit_flag;
   endproperty
   property p_sleep;
      sleep ##1 sleep |=> p1_min_bus_volt_sel == 2'b10 && p1_r2_min_current_sel == 3'b101;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_auto_drain: assert property (p_auto_drain) else $error("drain load not ignored");
   a_gate: assert property (p_gate) else $error("switch gate dropped");
   a_other: assert property (p_other) else $error("alert released early");
   a_release: assert property (p_release) else $error("alert not released");
   a_disable: assert property (p_disable) else $error("flag kept after disable");
   a_clear: assert property (p_clear) else $error("flag kept after clear");
   a_sleep: assert property (p_sleep) else $error("behaviour kept in sleep");
   c_flag: cover property ($rose(p1_quota_hit_flag));
   c_drain: cover property (p1_drain_load && p1_switch_gate);
   c_sleep: cover property (sleep ##1 sleep);
endmodule
bind port_charge_ration_regs ration_monitor i_mon (.sys_clk, .reset_n, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .sleep, .auto_drain_enable, .p1_switch_on, .p1_other_alert,
   .p1_drain_load, .p1_switch_gate, .p1_alert_n, .p1_quota_hit_flag, .p2_quota_hit_flag,
   .p1_min_bus_volt_sel, .p1_r2_min_current_sel);

// [tb_top.sv]
// Purpose: Self-checking bench of the ration bank
// Assumes: Short update period of 20 cycles
// Notes:   Both ports share one random charge step
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int UPD = 20;
   localparam logic [15:0] RST_TAB [9] = '{16'h1eff, 16'h1fff, 16'h20ff, 16'h21ff, 16'h2211,
      16'h2396, 16'h2496, 16'h1a00, 16'h3000};
   localparam logic [1:0] RESP_ORD [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
   logic        sys_clk, reset_n, reg_wr, reg_rd, active, sleep, auto_drain_enable;
   logic        p1_switch_on, p2_switch_on, p1_other_alert, p2_other_alert, sleep_req;
   logic        p1_drain_load, p2_drain_load, p1_switch_gate, p2_switch_gate;
   logic        p1_alert_n, p2_alert_n, p1_quota_hit_flag, p2_quota_hit_flag;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, e;
   logic [15:0] p1_charge_step, p2_charge_step, st;
   logic [1:0]  p1_min_bus_volt_sel, p2_min_bus_volt_sel, rc;
   logic [2:0]  p1_r2_min_current_sel, p2_r2_min_current_sel;
   logic [31:0] tot;
   int          error_cnt, n_compared, seed, k, n;
   port_charge_ration_regs #(.UPDATE_CYCLES(UPD)) i_dut (.sys_clk, .reset_n, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .active, .sleep, .auto_drain_enable, .p1_switch_on,
      .p2_switch_on, .p1_other_alert, .p2_other_alert, .p1_charge_step, .p2_charge_step,
      .reg_rdata, .p1_drain_load, .p2_drain_load, .p1_switch_gate, .p2_switch_gate,
      .p1_alert_n, .p2_alert_n, .sleep_req, .p1_quota_hit_flag, .p2_quota_hit_flag,
      .p1_min_bus_volt_sel, .p2_min_bus_volt_sel, .p1_r2_min_current_sel,
      .p2_r2_min_current_sel);
   host_model i_host (.sys_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
   // Threshold of one count is 1024 accumulator counts
   function automatic int steps_to_hit(input logic [15:0] s);
      return (1024 + s - 1) / s;
   endfunction
   task automatic tally_and_finish();
      if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic settle(input int c);
      repeat (c) @(posedge sys_clk);
      #1;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   initial begin
      #(40 * 20000);
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      seed = 32'h1a7e4710;
      {reset_n, active, sleep, auto_drain_enable, p1_other_alert, p2_other_alert} = '0;
      {p1_switch_on, p2_switch_on, p1_charge_step, p2_charge_step} = {2'b11, 32'h0};
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      // ----------------------------------------
      // Reset values, registers, accumulation
      // ----------------------------------------
      foreach (RST_TAB[i]) begin
         i_host.rd(RST_TAB[i][15:8], d);
         `CHK(d, RST_TAB[i][7:0])
      end
      for (int a = 8'h1e; a <= 8'h21; a++) begin
         e = 8'($random(seed));
         i_host.wr(a[7:0], e);
         i_host.rd(a[7:0], d);
         `CHK(d, e)
      end
      for (int v = 0; v < 4; v++) begin
         for (int c = 0; c < 6; c++) begin
            i_host.beh(8'h24, v[1:0], 1'b0, c[2:0]);
            i_host.beh(8'h23, ~v[1:0], 1'b0, 3'(5 - c));
            settle(2);
            `CHK({p1_min_bus_volt_sel, p1_r2_min_current_sel}, {v[1:0], c[2:0]})
            `CHK({p2_min_bus_volt_sel, p2_r2_min_current_sel}, {~v[1:0], 3'(5 - c)})
         end
      end
      i_host.rd(8'h24, d);
      `CHK(d, 8'hd6)
      i_host.beh(8'h24, 2'b10, 1'b1, 3'b101);
      i_host.beh(8'h23, 2'b10, 1'b1, 3'b101);
      settle(2);
      `CHK({p1_drain_load, p1_switch_gate}, 2'b11)
      `CHK({p2_drain_load, p2_switch_gate}, 2'b11)
      auto_drain_enable <= 1'b1;
      settle(2);
      `CHK({p1_drain_load, p2_drain_load}, 2'b00)
      auto_drain_enable <= 1'b0;
      i_host.beh(8'h23, 2'b10, 1'b0, 3'b101);
      settle(2);
      `CHK(p2_drain_load, 1'b0)
      i_host.beh(8'h24, 2'b01, 1'b0, 3'b011);
      sleep <= 1'b1;
      repeat (3) @(posedge sys_clk);
      sleep <= 1'b0;
      i_host.rd(8'h24, d);
      `CHK(d, 8'h96)
      for (int a = 8'h1e; a <= 8'h21; a++) i_host.wr(a[7:0], {7'h0, a[0]});
      for (int i = 0; i < 4; i++) begin
         rc = RESP_ORD[i];
         st = 16'(100 + {$random(seed)} % 500);
         p1_charge_step <= st;
         p2_charge_step <= st;
         i_host.wr(8'h22, {2'b11, rc, 2'b11, rc});
         i_host.wr(8'h22, {2'b10, rc, 2'b10, rc});
         active <= 1'b1;
         k = 0;
         while (p1_quota_hit_flag !== 1'b1 && k < 400) begin
            @(posedge sys_clk);
            k++;
         end
         active <= 1'b0;
         n = steps_to_hit(st);
         `CHK(k >= (n - 1) * UPD && k <= n * UPD + 2, 1'b1)
         settle(2);
         `CHK(p1_alert_n, !(rc == 2'b01 || rc == 2'b10))
         `CHK({p2_switch_gate, sleep_req, p2_quota_hit_flag}, {rc != 2'b10, rc == 2'b10, 1'b1})
         tot = 32'(n * st) << 6;
         for (int j = 0; j < 8; j++) begin
            i_host.rd(8'(8'h16 + j), d);
            `CHK(d, tot[31 - 8 * (j % 4) -: 8])
         end
      end
      p1_other_alert <= 1'b1;
      i_host.wr(8'h22, 8'hea);
      settle(3);
      `CHK({p1_quota_hit_flag, p1_alert_n}, 2'b00)
      p1_other_alert <= 1'b0;
      settle(2);
      `CHK(p1_alert_n, 1'b1)
      i_host.wr(8'h22, 8'ha2);
      settle(3);
      `CHK({p2_quota_hit_flag, p2_switch_gate, sleep_req, p2_alert_n}, 4'b0101)
      active <= 1'b1;
      settle(2 * UPD + 5);
      for (int a = 8'h19; a <= 8'h1a; a++) begin
         i_host.rd(a[7:0], d);
         `CHK(d, 8'h00)
      end
      tally_and_finish();
   end
endmodule
